// [pbfc_bridge_config.sv]
// Configuration header logic of the local-bus bridge function.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - First function minimum grant reads fixed 05h.
// - First function maximum latency reads fixed 0Fh.
// - Identity word returns vendor and device codes.
// - All-zero command half ignores non-config accesses.
// - Status bits cleared by writing one only.
// - Unsupported command bits read zero, read-only.
// - Memory space bit gates local-bus window accesses.
// - Parity response bit enables acting on errors.
// - System error enable gates the error pin.
// - Fixed status bits; fast back-to-back target one.
// - Medium device-select timing, reported and met.
// - Target abort sets sticky flag, write-one-clear.
// - System error assertion sets sticky flag always.
// - Parity error detection sets sticky flag always.
// - Revision and class word is read-only.
// - Mode pin selects bridge or configuration mode.
module pbfc_bridge_config #(
    parameter logic [15:0] VENDOR_CODE = 16'h1A2B, // Arbitrary value.
    parameter logic [15:0] DEVICE_CODE = 16'h5C6D, // Arbitrary value.
    parameter logic [7:0] REVISION_CODE = 8'h00 // Revision byte.
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_req,
    input wire pbfc_pkg::pbfc_cfg_req_t i_cfg,
    input wire logic i_mem_req,
    input wire logic i_arb_mode,
    input wire logic i_local_bus_granted,
    input wire logic i_local_mode_select,
    input wire logic i_parity_err,
    input wire logic i_serr_event,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    output logic o_mem_claim,
    output logic o_target_abort,
    output logic o_parity_act,
    output logic o_device_select_pin_n,
    output logic o_device_select_pin_oe,
    output logic o_system_error_pin_n,
    output logic o_system_error_pin_oe,
    output logic o_memory_space_control,
    output logic o_local_mode_select
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // An all-ones vendor code means "no device" to enumeration software.
    if (VENDOR_CODE == 16'hFFFF) begin : g_bad_vendor
        $error("VENDOR_CODE of all ones marks an absent function");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic mem_ctl_reg; // memory_space_control.
    logic parity_ctl_reg; // parity_response_control.
    logic serr_en_reg; // system_error_enable.
    logic target_abort_signalled_reg; // target_abort_signalled.
    logic serr_flag_reg; // system_error_signalled.
    logic perr_flag_reg; // parity_error_detected.
    logic lms_meta_reg; // First synchroniser stage of the mode pin.
    logic lms_reg; // Synchronised mode pin, high for configuration mode.
    logic gnt_meta_reg; // First synchroniser stage of the grant pin.
    logic gnt_reg; // Synchronised local-bus grant.
    pbfc_pkg::pbfc_claim_t claim_reg; // Decision taken one cycle after the address.
    pbfc_pkg::pbfc_claim_t claim_next;
    logic [15:0] cmd_half; // Command half as read back.
    logic [15:0] sts_half; // Status half as read back.
    logic [31:0] rdata_next; // Read data for the access in progress.
    logic cfg_wr; // A configuration write is taken this cycle.
    logic cmd_lo_wr; // Write reaches command byte 0.
    logic cmd_hi_wr; // Write reaches command byte 1.
    logic sts_hi_wr; // Write reaches status byte 3.
    logic serr_fire; // The device asserts its system error this cycle.

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Both pins come from the board, so each passes two flip-flops and
    // only the second stage is looked at by any logic.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            lms_meta_reg <= 1'h0;
            lms_reg <= 1'h0;
            gnt_meta_reg <= 1'h0;
            gnt_reg <= 1'h0;
        end else begin
            lms_meta_reg <= i_local_mode_select;
            lms_reg <= lms_meta_reg;
            gnt_meta_reg <= i_local_bus_granted;
            gnt_reg <= gnt_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // Only the command/status word holds anything writable; every other
    // mapped word ignores writes entirely.
    assign cfg_wr = i_cfg_req && i_cfg.we;
    assign cmd_lo_wr = cfg_wr && (i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2])
        && i_cfg.be[0];
    assign cmd_hi_wr = cfg_wr && (i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2])
        && i_cfg.be[1];
    assign sts_hi_wr = cfg_wr && (i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2])
        && i_cfg.be[3];

    // The system error is raised by the internal event whether or not
    // the pin is enabled; the enable only decides whether the pin moves.
    assign serr_fire = i_serr_event;

    // ------------------------------------------------------------------
    // Command bits
    // ------------------------------------------------------------------
    // Bits 0, 2-5, 7, 9 and 10-15 have no storage and so cannot be set.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            mem_ctl_reg <= pbfc_pkg::PBFC_CMD_RESET;
            parity_ctl_reg <= pbfc_pkg::PBFC_CMD_RESET;
            serr_en_reg <= pbfc_pkg::PBFC_CMD_RESET;
        end else begin
            if (cmd_lo_wr) begin
                mem_ctl_reg <= i_cfg.wdata[pbfc_pkg::PBFC_CMD_MEM_BIT];
                parity_ctl_reg <= i_cfg.wdata[pbfc_pkg::PBFC_CMD_PARITY_BIT];
            end
            if (cmd_hi_wr) begin
                serr_en_reg <= i_cfg.wdata[pbfc_pkg::PBFC_CMD_SERR_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    // Each flag is set by hardware and cleared by a written one. A set in
    // the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            target_abort_signalled_reg <= pbfc_pkg::PBFC_STS_RESET;
            serr_flag_reg <= pbfc_pkg::PBFC_STS_RESET;
            perr_flag_reg <= pbfc_pkg::PBFC_STS_RESET;
        end else begin
            if (claim_reg == pbfc_pkg::PBFC_ABORT) begin
                target_abort_signalled_reg <= 1'h1;
            end else if (sts_hi_wr && i_cfg.wdata[pbfc_pkg::PBFC_STS_TARGET_ABORT_SIGNALLED_BIT]) begin
                target_abort_signalled_reg <= 1'h0;
            end
            if (serr_fire) begin
                serr_flag_reg <= 1'h1;
            end else if (sts_hi_wr && i_cfg.wdata[pbfc_pkg::PBFC_STS_SERR_BIT]) begin
                serr_flag_reg <= 1'h0;
            end
            if (i_parity_err) begin
                perr_flag_reg <= 1'h1;
            end else if (sts_hi_wr && i_cfg.wdata[pbfc_pkg::PBFC_STS_PERR_BIT]) begin
                perr_flag_reg <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read-back words
    // ------------------------------------------------------------------
    // Fixed fields are built from constants, never from storage.
    always_comb begin
        cmd_half = 16'h0000;
        cmd_half[pbfc_pkg::PBFC_CMD_MEM_BIT] = mem_ctl_reg;
        cmd_half[pbfc_pkg::PBFC_CMD_PARITY_BIT] = parity_ctl_reg;
        cmd_half[pbfc_pkg::PBFC_CMD_SERR_BIT] = serr_en_reg;
        sts_half = 16'h0000;
        sts_half[pbfc_pkg::PBFC_STS_FBB_BIT - 16] = pbfc_pkg::PBFC_FBB_TARGET;
        sts_half[pbfc_pkg::PBFC_STS_DEVSEL_LSB - 16 +: 2] = pbfc_pkg::PBFC_DEVSEL_MEDIUM;
        sts_half[pbfc_pkg::PBFC_STS_TARGET_ABORT_SIGNALLED_BIT - 16] = target_abort_signalled_reg;
        sts_half[pbfc_pkg::PBFC_STS_SERR_BIT - 16] = serr_flag_reg;
        sts_half[pbfc_pkg::PBFC_STS_PERR_BIT - 16] = perr_flag_reg;
    end

    // Read multiplexer; unmapped words read as zero. The low half of the
    // first function's grant word belongs to other logic and reads zero.
    always_comb begin
        if (i_cfg.addr[11:2] == pbfc_pkg::PBFC_FN0_GRANT_OFS[11:2]) begin
            rdata_next = {pbfc_pkg::PBFC_MAX_LATENCY, pbfc_pkg::PBFC_MIN_GRANT, 16'h0000};
        end else if (i_cfg.addr[11:2] == pbfc_pkg::PBFC_IDENT_OFS[11:2]) begin
            rdata_next = {DEVICE_CODE, VENDOR_CODE};
        end else if (i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2]) begin
            rdata_next = {sts_half, cmd_half};
        end else if (i_cfg.addr[11:2] == pbfc_pkg::PBFC_REVCLS_OFS[11:2]) begin
            rdata_next = {pbfc_pkg::PBFC_CLASS_BASE, pbfc_pkg::PBFC_CLASS_SUB,
                pbfc_pkg::PBFC_CLASS_IFACE, REVISION_CODE};
        end else begin
            rdata_next = 32'h0000_0000;
        end
    end

    // Every configuration access is answered one cycle after it is taken;
    // configuration accesses are never gated by the command bits.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_cfg_ack <= 1'h0;
            o_cfg_rdata <= 32'h0000_0000;
        end else begin
            o_cfg_ack <= i_cfg_req;
            if (i_cfg_req && !i_cfg.we) begin
                o_cfg_rdata <= rdata_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Local-bus window decode
    // ------------------------------------------------------------------
    // An access is ignored while the command half is all zero, while the
    // memory bit is off, or in configuration mode, where the host has no
    // way onto the local bus. With arbitration on and no grant held the
    // access ends in target abort.
    always_comb begin
        if ((cmd_half == 16'h0000) || !mem_ctl_reg) begin
            claim_next = pbfc_pkg::PBFC_IDLE;
        end else if (!i_mem_req || lms_reg) begin
            claim_next = pbfc_pkg::PBFC_IDLE;
        end else if (i_arb_mode && !gnt_reg) begin
            claim_next = pbfc_pkg::PBFC_ABORT;
        end else begin
            claim_next = pbfc_pkg::PBFC_ACCEPT;
        end
    end

    // The decision is held one cycle so the select pin drops in the second
    // clock after the address phase: medium decode, never fast.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            claim_reg <= pbfc_pkg::PBFC_IDLE;
            o_mem_claim <= 1'h0;
            o_target_abort <= 1'h0;
            o_device_select_pin_n <= 1'h1;
            o_device_select_pin_oe <= 1'h0;
        end else begin
            claim_reg <= claim_next;
            o_mem_claim <= (claim_reg == pbfc_pkg::PBFC_ACCEPT);
            o_target_abort <= (claim_reg == pbfc_pkg::PBFC_ABORT);
            o_device_select_pin_n <= (claim_reg == pbfc_pkg::PBFC_IDLE);
            o_device_select_pin_oe <= (claim_reg != pbfc_pkg::PBFC_IDLE);
        end
    end

    // ------------------------------------------------------------------
    // Error outputs and level outputs
    // ------------------------------------------------------------------
    // The open-drain error pin is only ever pulled low, and only while
    // enabled; the flag above records the event regardless.
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            o_system_error_pin_n <= 1'h1;
            o_system_error_pin_oe <= 1'h0;
            o_parity_act <= 1'h0;
            o_memory_space_control <= 1'h0;
            o_local_mode_select <= 1'h0;
        end else begin
            o_system_error_pin_n <= !(serr_fire && serr_en_reg);
            o_system_error_pin_oe <= serr_fire && serr_en_reg;
            o_parity_act <= i_parity_err && parity_ctl_reg;
            o_memory_space_control <= mem_ctl_reg;
            o_local_mode_select <= lms_reg;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    min_grant_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_FN0_GRANT_OFS[11:2])
        |=> (o_cfg_ack && o_cfg_rdata[23:16] == 8'h05))
        else $error("minimum grant byte wrong");

    max_latency_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_FN0_GRANT_OFS[11:2])
        |=> (o_cfg_rdata[31:24] == 8'h0F))
        else $error("maximum latency byte wrong");

    identity_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_IDENT_OFS[11:2])
        |=> (o_cfg_rdata == {DEVICE_CODE, VENDOR_CODE}))
        else $error("identity word wrong");

    cmd_zero_ignore_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_mem_req && cmd_half == 16'h0000) |-> ##2 !o_device_select_pin_oe)
        else $error("access claimed with command half zero");

    status_clear_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (sts_hi_wr && i_cfg.wdata[31] && !i_parity_err) |=> !perr_flag_reg ##1
        (!perr_flag_reg || $past(i_parity_err)))
        else $error("status clear failed");

    status_no_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!perr_flag_reg && !i_parity_err) |=> !perr_flag_reg)
        else $error("status bit set without event");

    cmd_fixed_zero_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2])
        |=> ((o_cfg_rdata & 32'h0000_FEBD) == 32'h0000_0000))
        else $error("read-only command bits not zero");

    mem_gate_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_mem_req && mem_ctl_reg && !lms_reg && !i_arb_mode) |-> ##2 o_mem_claim)
        else $error("enabled memory access not accepted");

    parity_resp_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_parity_err |=> (o_parity_act == $past(parity_ctl_reg)))
        else $error("parity response wrong");

    serr_pin_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_system_error_pin_oe |-> ($past(serr_en_reg) && !o_system_error_pin_n))
        else $error("error pin driven while disabled");

    fixed_status_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_CMDSTS_OFS[11:2])
        |=> ((o_cfg_rdata & 32'h37FF_0000) == 32'h0280_0000))
        else $error("fixed status bits wrong");

    devsel_medium_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (claim_next != pbfc_pkg::PBFC_IDLE && claim_reg == pbfc_pkg::PBFC_IDLE)
        |=> !o_device_select_pin_oe ##1
        (o_device_select_pin_oe && !o_device_select_pin_n))
        else $error("device select not at medium timing");

    target_abort_signalled_set_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (claim_next == pbfc_pkg::PBFC_ABORT) |-> ##2 (target_abort_signalled_reg && o_target_abort))
        else $error("target abort not flagged");

    serr_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_serr_event |=> serr_flag_reg)
        else $error("system error flag not set");

    perr_flag_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        i_parity_err |=> perr_flag_reg)
        else $error("parity error flag not set");

    class_read_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_cfg_req && !i_cfg.we && i_cfg.addr[11:2] == pbfc_pkg::PBFC_REVCLS_OFS[11:2])
        |=> (o_cfg_rdata[31:8] == 24'h0680_00))
        else $error("class code wrong");

    slave_ignore_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_mem_req && lms_reg) |-> ##2 !o_device_select_pin_oe)
        else $error("access claimed in configuration mode");

    reset_clear_a: assert property (
        @(posedge i_sys_clk)
        !i_rst_n |=> (!target_abort_signalled_reg && !serr_flag_reg && !perr_flag_reg && !mem_ctl_reg))
        else $error("reset left a flag set");

endmodule

`default_nettype wire

// [pbfc_host_model.sv]
// PCI host model that issues configuration and memory-window requests.
`timescale 1ns/10ps
`default_nettype none
module pbfc_host_model (
    input wire logic i_sys_clk,
    input wire logic i_cfg_ack,
    input wire logic [31:0] i_cfg_rdata,
    output logic o_cfg_req,
    output pbfc_pkg::pbfc_cfg_req_t o_cfg,
    output logic o_mem_req
);
    // ------------------------------------------------------------------
    // Bus idle at time zero
    // ------------------------------------------------------------------
    initial begin
        o_cfg_req = 1'h0;
        o_cfg = '0;
        o_mem_req = 1'h0;
    end

    // One configuration access, answered one edge after it is taken.
    task automatic cfg_access(input logic we, input logic [11:0] addr, input logic [3:0] be,
            input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
        @(posedge i_sys_clk) #1;
        o_cfg_req = 1'h1;
        o_cfg = '{we: we, addr: addr, be: be, wdata: wdata};
        @(posedge i_sys_clk) #1;
        o_cfg_req = 1'h0;
        // Released lines flip so that stale data can never pass for fresh.
        o_cfg = ~o_cfg;
        ack = i_cfg_ack;
        rdata = i_cfg_rdata;
    endtask

    // One window address phase; the caller looks at the claim two edges on.
    // In slave mode the memory bit is kept off unless a test means otherwise.
    task automatic mem_access();
        @(posedge i_sys_clk) #1;
        o_mem_req = 1'h1;
        @(posedge i_sys_clk) #1;
        o_mem_req = 1'h0;
        @(posedge i_sys_clk) #1;
    endtask
endmodule
`default_nettype wire

// [pbfc_pkg.sv]
// Shared constants and types for the bridge function configuration header.
package pbfc_pkg;

    // ------------------------------------------------------------------
    // Register offsets in configuration space (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] PBFC_FN0_GRANT_OFS = 12'h03C; // First function grant/latency word.
    localparam logic [11:0] PBFC_IDENT_OFS = 12'h100; // bridge_identity.
    localparam logic [11:0] PBFC_CMDSTS_OFS = 12'h104; // bridge_command_status.
    localparam logic [11:0] PBFC_REVCLS_OFS = 12'h108; // bridge_revision_class.

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PBFC_CMD_MEM_BIT = 1; // memory_space_control.
    localparam int PBFC_CMD_PARITY_BIT = 6; // parity_response_control.
    localparam int PBFC_CMD_SERR_BIT = 8; // system_error_enable.
    localparam int PBFC_STS_FBB_BIT = 23; // fast_b2b_target_capable.
    localparam int PBFC_STS_DEVSEL_LSB = 25; // devsel_timing_lo.
    localparam int PBFC_STS_TARGET_ABORT_SIGNALLED_BIT = 27; // target_abort_signalled.
    localparam int PBFC_STS_SERR_BIT = 30; // system_error_signalled.
    localparam int PBFC_STS_PERR_BIT = 31; // parity_error_detected.

    // ------------------------------------------------------------------
    // Fixed values and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] PBFC_MIN_GRANT = 8'h05; // Burst need in 0.25 us units at 33 MHz.
    localparam logic [7:0] PBFC_MAX_LATENCY = 8'h0F; // Access interval in 0.25 us units.
    localparam logic [7:0] PBFC_CLASS_IFACE = 8'h00; // Class code interface byte.
    localparam logic [7:0] PBFC_CLASS_SUB = 8'h80; // Other bridge sub-class.
    localparam logic [7:0] PBFC_CLASS_BASE = 8'h06; // Bridge base class.
    localparam logic [1:0] PBFC_DEVSEL_MEDIUM = 2'h1; // Medium device-select timing code.
    localparam logic PBFC_FBB_TARGET = 1'h1; // Fast back-to-back target capable.
    localparam logic PBFC_CMD_RESET = 1'h0; // Reset value of every writable command bit.
    localparam logic PBFC_STS_RESET = 1'h0; // Reset value of every status flag.

    // ------------------------------------------------------------------
    // Timing: medium decode claims in the second clock after the address
    // ------------------------------------------------------------------
    localparam int PBFC_DEVSEL_CYCLES = 2; // Cycles from address phase to device select.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // One configuration access as presented by the bus front end.
    typedef struct packed {
        logic we; // High for a write, low for a read.
        logic [11:0] addr; // Configuration byte address.
        logic [3:0] be; // Byte lane enables for writes.
        logic [31:0] wdata; // Write data.
    } pbfc_cfg_req_t;

    // Outcome of a host access aimed at the local-bus memory window.
    typedef enum logic [1:0] {
        PBFC_IDLE,
        PBFC_ACCEPT,
        PBFC_ABORT
    } pbfc_claim_t;

endpackage

// [tb_top.sv]
// Self-checking testbench for the bridge function configuration header.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic i_sys_clk, i_rst_n, i_cfg_req, i_mem_req, i_arb_mode, i_local_bus_granted;
    logic i_local_mode_select, i_parity_err, i_serr_event;
    pbfc_pkg::pbfc_cfg_req_t i_cfg;
    logic o_cfg_ack, o_mem_claim, o_target_abort, o_parity_act, o_device_select_pin_n;
    logic o_device_select_pin_oe, o_system_error_pin_n, o_system_error_pin_oe;
    logic o_memory_space_control, o_local_mode_select;
    logic [31:0] o_cfg_rdata;
    int fails = 0; // Mismatches seen.
    int comparisons = 0; // Comparisons made.
    logic [11:0] ro_addr [4] = '{12'h100, 12'h108, 12'h03C, 12'h200};
    logic [31:0] ro_exp [4] = '{32'h5C6D1A2B, 32'h06800000, 32'h0F050000, 32'h0};

    pbfc_bridge_config #(.VENDOR_CODE(16'h1A2B), .DEVICE_CODE(16'h5C6D), .REVISION_CODE(8'h00))
        pbfc_bridge_config_i (.*);
    pbfc_host_model pbfc_host_model_i (.i_sys_clk(i_sys_clk), .i_cfg_ack(o_cfg_ack),
        .i_cfg_rdata(o_cfg_rdata), .o_cfg_req(i_cfg_req), .o_cfg(i_cfg), .o_mem_req(i_mem_req));

    // ------------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #50000;
        fails++;
        complete_run();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic ack;
        logic [31:0] d;
        pbfc_host_model_i.cfg_access(1'b0, a, 4'h0, 32'h0, ack, d);
        chk({31'h0, ack}, 32'h1);
        chk(d, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] v);
        logic ack;
        logic [31:0] d;
        pbfc_host_model_i.cfg_access(1'b1, a, be, v, ack, d);
        chk({31'h0, ack}, 32'h1);
    endtask
    // Window access: select is driven low exactly when claimed or aborted.
    task automatic mem(input logic cl, input logic ab);
        pbfc_host_model_i.mem_access();
        chk({o_mem_claim, o_target_abort, o_device_select_pin_oe, o_device_select_pin_n},
            {cl, ab, cl | ab, ~(cl | ab)});
    endtask
    task automatic pulse(input logic act, input logic oe);
        @(posedge i_sys_clk) #1;
        i_parity_err = 1'b1;
        i_serr_event = 1'b1;
        @(posedge i_sys_clk) #1;
        i_parity_err = 1'b0;
        i_serr_event = 1'b0;
        chk({o_parity_act, o_system_error_pin_oe, o_system_error_pin_n}, {act, oe, ~oe});
    endtask
    task automatic reset_dut();
        i_rst_n = 1'b0;
        repeat (3) @(posedge i_sys_clk);
        #1 i_rst_n = 1'b1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        {i_arb_mode, i_local_bus_granted, i_local_mode_select, i_parity_err} = 4'h0;
        i_serr_event = 1'h0;
        reset_dut();
        rd(12'h104, 32'h02800000);
        // Read-only words keep their values after an all-ones write.
        for (int i = 0; i < 4; i++) begin
            rd(ro_addr[i], ro_exp[i]);
            wr(ro_addr[i], 4'hF, 32'hFFFFFFFF);
            rd(ro_addr[i], ro_exp[i]);
        end
        wr(12'h104, 4'hF, 32'hFFFFFFFF);
        rd(12'h104, 32'h02800142);
        chk({31'h0, o_memory_space_control}, 32'h1);
        mem(1'h1, 1'h0);
        i_arb_mode = 1'h1;
        repeat (4) @(posedge i_sys_clk);
        mem(1'h0, 1'h1);
        rd(12'h104, 32'h0A800142);
        wr(12'h104, 4'h8, 32'h08000000);
        rd(12'h104, 32'h02800142);
        i_local_bus_granted = 1'h1;
        repeat (4) @(posedge i_sys_clk);
        mem(1'h1, 1'h0);
        pulse(1'h1, 1'h1);
        rd(12'h104, 32'hC2800142);
        wr(12'h104, 4'h8, 32'h40000000);
        rd(12'h104, 32'h82800142);
        wr(12'h104, 4'h3, 32'h0);
        mem(1'h0, 1'h0);
        // The level copies follow the cleared memory bit and the idle mode pin.
        chk({30'h0, o_memory_space_control, o_local_mode_select}, 32'h0);
        pulse(1'h0, 1'h0);
        rd(12'h104, 32'hC2800000);
        wr(12'h104, 4'h1, 32'h00000002);
        i_local_mode_select = 1'h1;
        repeat (4) @(posedge i_sys_clk);
        chk({31'h0, o_local_mode_select}, 32'h1);
        mem(1'h0, 1'h0);
        reset_dut();
        rd(12'h104, 32'h02800000);
        complete_run();
    end
endmodule
`default_nettype wire
